// ==== rtl/pds_top.sv ====
// Feedback divider (prescaler, swallow and main counters) with observation pin.
// Assumes all inputs synchronous to clk; clk stands for the divider input rate.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module pds_top
    import pds_pkg::*;
#(
    parameter int SWALLOW_W = A_W,
    parameter int MAIN_W    = B_W,
    parameter int REF_W     = R_W
) (
    input  wire logic              clk,            // 125 MHz clock
    input  wire logic              rst,            // Synchronous reset, high
    input  wire logic [ADDR_W-1:0] addr,           // Register address
    input  wire logic [DATA_W-1:0] wdata,          // Write data
    input  wire logic              wr,             // Write strobe
    input  wire logic              rd,             // Read strobe
    output logic      [DATA_W-1:0] rdata,          // Read data, one cycle later
    input  wire logic              pfd_up,         // Phase detector up pulse
    input  wire logic              pfd_down,       // Phase detector down pulse
    input  wire logic              first_ref_clk,  // First reference input
    input  wire logic              second_ref_clk, // Second reference input
    input  wire logic              second_ref_sel, // High: second reference selected, except in differential mode
    input  wire logic              diff_mode,      // Differential reference mode
    input  wire logic              first_ref_ok,   // First reference status
    input  wire logic              second_ref_ok,  // Second reference status
    input  wire logic              first_freq_ok,  // First reference frequency valid
    input  wire logic              second_freq_ok, // Second reference frequency valid
    input  wire logic              osc_freq_ok,    // Oscillator frequency valid
    input  wire logic              lock_ind,       // Digital lock indication
    input  wire logic              holdover,       // Holdover active
    output logic                   obs_pin,        // Observation pin
    output logic                   fb_div_out,     // Feedback divider toggle output
    output logic                   ref_div_out     // Reference divider toggle output
);
    initial begin
        if (SWALLOW_W < 1 || SWALLOW_W > 8) $error("pds_top: SWALLOW_W out of range");
        if (MAIN_W < 9 || MAIN_W > 16) $error("pds_top: MAIN_W out of range");
        if (REF_W < 9 || REF_W > 16) $error("pds_top: REF_W out of range");
    end

    // Configuration registers
    logic [7:0] ctl_reg;
    logic [7:0] obs_reg;
    logic [7:0] swallow_reg;
    logic [7:0] main_lo_reg;
    logic [7:0] main_hi_reg;
    logic [7:0] ref_lo_reg;
    logic [7:0] ref_hi_reg;

    wire hit_ctl     = (addr == FEEDBACK_CTL_OFF);
    wire hit_obs     = (addr == OBS_SEL_OFF);
    wire hit_swallow = (addr == SWALLOW_OFF);
    wire hit_main_lo = (addr == MAIN_LO_OFF);
    wire hit_main_hi = (addr == MAIN_HI_OFF);
    wire hit_ref_lo  = (addr == REF_DIV_LO_OFF);
    wire hit_ref_hi  = (addr == REF_DIV_HI_OFF);
    wire hit_status  = (addr == STATUS_OFF);

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_reg     <= FEEDBACK_CTL_RST;
            obs_reg     <= OBS_SEL_RST;
            swallow_reg <= SWALLOW_RST;
            main_lo_reg <= MAIN_LO_RST;
            main_hi_reg <= MAIN_HI_RST;
            ref_lo_reg  <= REF_DIV_LO_RST;
            ref_hi_reg  <= REF_DIV_HI_RST;
        end else if (wr) begin
            if (hit_ctl) ctl_reg <= wdata;
            if (hit_obs) obs_reg <= wdata;
            if (hit_swallow) swallow_reg <= wdata;
            if (hit_main_lo) main_lo_reg <= wdata;
            if (hit_main_hi) main_hi_reg <= wdata;
            if (hit_ref_lo) ref_lo_reg <= wdata;
            if (hit_ref_hi) ref_hi_reg <= wdata;
        end
    end

    // Decoded control fields
    wire [2:0] presc_code = ctl_reg[CTL_PRESC_LSB +: PRESC_W];
    wire       dual       = pds_is_dual(presc_code);
    wire       reset_all  = ctl_reg[CTL_RST_ALL_BIT];
    wire       reset_ab   = ctl_reg[CTL_RST_AB_BIT] || reset_all;
    wire       reset_ref  = ctl_reg[CTL_RST_REF_BIT] || reset_all;
    wire       bypass     = ctl_reg[CTL_BYPASS_BIT] && !dual;
    wire [5:0] obs_sel    = obs_reg[OBS_SEL_LSB +: OBS_SEL_W];

    wire [15:0] main_full = {main_hi_reg, main_lo_reg};
    wire [15:0] ref_full  = {ref_hi_reg, ref_lo_reg};
    wire [SWALLOW_W-1:0] swallow_val = swallow_reg[SWALLOW_W-1:0];
    wire [MAIN_W-1:0]    main_val    = main_full[MAIN_W-1:0];
    wire [REF_W-1:0]     ref_val     = ref_full[REF_W-1:0];

    // Swallow counter: busy for the first A prescaler periods; each sets the next period to the upper ratio
    logic [SWALLOW_W-1:0] swallow_cnt;
    logic                 p_tick;
    logic                 n_tick;
    wire                  swallow_busy = dual && (swallow_cnt != '0);
    wire                  swallow_done = p_tick && (swallow_cnt == SWALLOW_W'(1));

    always_ff @(posedge clk) begin
        if (rst || reset_ab) begin
            swallow_cnt <= swallow_val;
        end else if (n_tick) begin
            swallow_cnt <= swallow_val;
        end else if (p_tick && swallow_cnt != '0) begin
            swallow_cnt <= swallow_cnt - 1'b1;
        end
    end

    // Prescaler: base ratio, one more while swallowing
    wire [P_W-1:0] base_ratio  = pds_base_ratio(presc_code);
    wire [P_W-1:0] p_load      = base_ratio - (swallow_busy ? 6'h00 : 6'h01);

    pds_counter #(
        .WIDTH (P_W)
    ) u_presc (
        .clk  (clk),
        .rst  (rst),
        .clr  (reset_ab),
        .step (1'b1),
        .load (p_load),
        .tick (p_tick)
    );

    // Main counter; bypassed when the bypass bit is set in fixed divide, so each prescaler period ends a cycle
    wire [MAIN_W-1:0] main_load = (main_val == '0) ? '0 : main_val - 1'b1;
    logic             main_tick;

    pds_counter #(
        .WIDTH (MAIN_W)
    ) u_main (
        .clk  (clk),
        .rst  (rst),
        .clr  (reset_ab || bypass),
        .step (p_tick),
        .load (main_load),
        .tick (main_tick)
    );

    assign n_tick = bypass ? p_tick : main_tick;

    // Reference counter
    wire [REF_W-1:0] ref_load = (ref_val == '0) ? '0 : ref_val - 1'b1;
    logic            r_tick;

    pds_counter #(
        .WIDTH (REF_W)
    ) u_ref (
        .clk  (clk),
        .rst  (rst),
        .clr  (reset_ref),
        .step (1'b1),
        .load (ref_load),
        .tick (r_tick)
    );

    // Toggle outputs, so each divider shows as a running clock
    logic n_toggle;
    logic r_toggle;
    logic a_toggle;
    logic p_toggle;
    logic n_delayed;
    logic r_delayed;

    always_ff @(posedge clk) begin
        if (rst) begin
            n_toggle  <= 1'b0;
            r_toggle  <= 1'b0;
            a_toggle  <= 1'b0;
            p_toggle  <= 1'b0;
            n_delayed <= 1'b0;
            r_delayed <= 1'b0;
        end else begin
            n_toggle  <= n_toggle ^ n_tick;
            r_toggle  <= r_toggle ^ r_tick;
            a_toggle  <= a_toggle ^ swallow_done;
            p_toggle  <= p_toggle ^ p_tick;
            n_delayed <= n_toggle;
            r_delayed <= r_toggle;
        end
    end

    // Reference monitor style selections
    // Differential mode always runs the loop from the first input
    wire sel_second    = second_ref_sel && !diff_mode;
    wire sel_ref_clk   = sel_second ? second_ref_clk : first_ref_clk;
    wire unsel_ref_clk = !diff_mode && (second_ref_sel ? first_ref_clk : second_ref_clk);
    wire sel_ref_ok    = sel_second ? second_ref_ok : first_ref_ok;
    wire unsel_ref_ok  = !diff_mode && (second_ref_sel ? first_ref_ok : second_ref_ok);
    wire second_reference_input_avail    = !diff_mode && second_ref_clk;

    wire [31:0] low_set = {
        25'h0000000,
        pfd_down,      // 6
        pfd_up,        // 5
        p_toggle,      // 4
        a_toggle,      // 3
        r_delayed,     // 2
        n_delayed,     // 1
        1'b0           // 0
    };

    wire [31:0] high_set = {
        17'h00000,
        holdover,                                 // 14
        lock_ind,                                 // 13
        second_ref_sel,                           // 12
        osc_freq_ok,                              // 11
        lock_ind && sel_ref_ok && osc_freq_ok,    // 10
        first_freq_ok && second_freq_ok,          // 9
        second_freq_ok,                           // 8
        first_freq_ok,                            // 7
        unsel_ref_ok,                             // 6
        sel_ref_ok,                               // 5
        unsel_ref_clk,                            // 4
        sel_ref_clk,                              // 3
        second_reference_input_avail,                               // 2
        first_ref_clk,                            // 1
        1'b0                                      // 0
    };

    wire next_obs_pin = obs_sel[5] ? high_set[obs_sel[4:0]] : low_set[obs_sel[4:0]];

    // Readback of block state
    wire [7:0] status_word = {
        2'b00,
        swallow_busy,
        bypass,
        dual,
        obs_pin,
        n_toggle,
        r_toggle
    };

    wire [7:0] next_rdata =
        !rd         ? 8'h00 :
        hit_ctl     ? ctl_reg :
        hit_obs     ? obs_reg :
        hit_swallow ? {2'b00, swallow_reg[5:0]} :
        hit_main_lo ? main_lo_reg :
        hit_main_hi ? {3'b000, main_hi_reg[4:0]} :
        hit_ref_lo  ? ref_lo_reg :
        hit_ref_hi  ? {2'b00, ref_hi_reg[5:0]} :
        hit_status  ? status_word :
        8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            obs_pin     <= 1'b0;
            fb_div_out  <= 1'b0;
            ref_div_out <= 1'b0;
            rdata       <= 8'h00;
        end else begin
            obs_pin     <= next_obs_pin;
            fb_div_out  <= n_toggle;
            ref_div_out <= r_toggle;
            rdata       <= next_rdata;
        end
    end
endmodule

// ==== include/pds_pkg.sv ====
// Constants for the feedback divider control and observation pin selector.
// Assumes a single synchronous clock domain and a plain strobe register port.
//
// How it works
// - Codes two and three divide by two/three or four/five, lower ratio when swallow is zero.
// - Code four divides by eight and nine, eight alone when swallow is zero.
// - Code five divides by sixteen and seventeen, sixteen alone when swallow is zero.
// - Code six divides by thirty-two and thirty-three, thirty-two alone when swallow zero.
// - Main-counter bypass acts only in fixed divide; ratio then equals prescaler setting.
// - Select code zero and unassigned low-half codes drive the pin low.
// - Low codes one to six show feedback, reference, swallow, prescaler, up, down.
// - High-half codes follow the reference monitor list; code zero drives low.
// - High codes one and two show first and second reference clocks; code two is low in differential mode.
// - High codes three and four show selected and unselected reference clocks.
// - High codes five and six show selected and unselected reference status.
// - High codes seven and eight show first and second reference frequency valid.
// - High code nine shows AND of both reference frequency flags.
// - High code ten shows lock AND selected status AND oscillator status.
// - High code eleven shows oscillator frequency valid.
// - High code twelve shows the raw select input, high when second is requested, even in differential mode.
// - High code thirteen shows digital lock indication.
// - High code fourteen shows holdover active.
package pds_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int A_W    = 6;
    localparam int B_W    = 13;
    localparam int R_W    = 14;
    localparam int P_W    = 6;

    localparam logic [7:0] REF_DIV_LO_OFF   = 8'h11;
    localparam logic [7:0] REF_DIV_HI_OFF   = 8'h12;
    localparam logic [7:0] SWALLOW_OFF      = 8'h13;
    localparam logic [7:0] MAIN_LO_OFF      = 8'h14;
    localparam logic [7:0] MAIN_HI_OFF      = 8'h15;
    localparam logic [7:0] FEEDBACK_CTL_OFF = 8'h16;
    localparam logic [7:0] OBS_SEL_OFF      = 8'h17;
    localparam logic [7:0] STATUS_OFF       = 8'h1F;

    localparam int CTL_RST_REF_BIT  = 6;
    localparam int CTL_RST_AB_BIT   = 5;
    localparam int CTL_RST_ALL_BIT  = 4;
    localparam int CTL_BYPASS_BIT   = 3;
    localparam int CTL_PRESC_LSB    = 0;
    localparam int PRESC_W          = 3;
    localparam int OBS_SEL_LSB      = 2;
    localparam int OBS_SEL_W        = 6;

    localparam logic [7:0] FEEDBACK_CTL_RST = 8'h00;
    localparam logic [7:0] OBS_SEL_RST      = 8'h00;
    localparam logic [7:0] SWALLOW_RST      = 8'h00;
    localparam logic [7:0] MAIN_LO_RST      = 8'h01;
    localparam logic [7:0] MAIN_HI_RST      = 8'h00;
    localparam logic [7:0] REF_DIV_LO_RST   = 8'h01;
    localparam logic [7:0] REF_DIV_HI_RST   = 8'h00;

    typedef enum logic [2:0] {
        PDS_FIXED_1  = 3'h0,
        PDS_FIXED_2  = 3'h1,
        PDS_DUAL_2_3 = 3'h2,
        PDS_DUAL_4_5 = 3'h3,
        PDS_DUAL_8_9 = 3'h4,
        PDS_DUAL_16  = 3'h5,
        PDS_DUAL_32  = 3'h6,
        PDS_FIXED_3  = 3'h7
    } pds_presc_type;

    // Base (lower) prescaler ratio
    function automatic logic [P_W-1:0] pds_base_ratio(input logic [2:0] code);
        case (pds_presc_type'(code))
            PDS_FIXED_1:  pds_base_ratio = 6'h01;
            PDS_FIXED_2:  pds_base_ratio = 6'h02;
            PDS_DUAL_2_3: pds_base_ratio = 6'h02;
            PDS_DUAL_4_5: pds_base_ratio = 6'h04;
            PDS_DUAL_8_9: pds_base_ratio = 6'h08;
            PDS_DUAL_16:  pds_base_ratio = 6'h10;
            PDS_DUAL_32:  pds_base_ratio = 6'h20;
            default:      pds_base_ratio = 6'h03;
        endcase
    endfunction

    // True for the dual-modulus settings
    function automatic logic pds_is_dual(input logic [2:0] code);
        pds_is_dual = (code >= 3'h2) && (code <= 3'h6);
    endfunction
endpackage

// ==== rtl/pds_counter.sv ====
// Reloading down counter; a tick marks each full period of load+1 steps.
// Assumes clear and step are synchronous to clk.
`timescale 1ns/1ps
module pds_counter #(
    parameter int WIDTH = 13
) (
    input  wire logic             clk,   // System clock
    input  wire logic             rst,   // Synchronous reset
    input  wire logic             clr,   // Hold at load value
    input  wire logic             step,  // Count one step
    input  wire logic [WIDTH-1:0] load,  // Period minus one
    output logic                  tick   // Last step of period
);
    logic [WIDTH-1:0] count;
    wire              at_end = (count == '0);

    initial begin
        if (WIDTH < 1) $error("pds_counter: WIDTH must be at least 1");
    end

    assign tick = step && at_end && !clr;

    always_ff @(posedge clk) begin
        if (rst || clr) begin
            count <= load;
        end else if (step) begin
            count <= at_end ? load : count - 1'b1;
        end
    end
endmodule

// ==== verif/pds_assertions.sv ====
// Checker for the observation pin selector and register read port of pds_top.
// Assumes one clock domain; shadows the select register from observed writes.
`timescale 1ns/1ps
module pds_assertions
    import pds_pkg::*;
(
    input wire logic              clk,            // Clock
    input wire logic              rst,            // Synchronous reset
    input wire logic [ADDR_W-1:0] addr,           // Register address
    input wire logic [DATA_W-1:0] wdata,          // Write data
    input wire logic              wr,             // Write strobe
    input wire logic              rd,             // Read strobe
    input wire logic [DATA_W-1:0] rdata,          // Read data
    input wire logic              pfd_up,         // Phase detector up
    input wire logic              second_ref_sel, // Second reference selected
    input wire logic              first_freq_ok,  // First frequency valid
    input wire logic              second_freq_ok, // Second frequency valid
    input wire logic              osc_freq_ok,    // Oscillator valid
    input wire logic              lock_ind,       // Lock indication
    input wire logic              holdover,       // Holdover active
    input wire logic              obs_pin         // Observation pin
);
    logic [7:0] obs_q;
    wire  [5:0] sel = obs_q[7:2];
    always_ff @(posedge clk) begin
        if (rst) obs_q <= 8'h00;
        else if (wr && addr == OBS_SEL_OFF) obs_q <= wdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
    sel_readback_a: assert property (rd && addr == OBS_SEL_OFF |=> rdata == obs_q) else $error("select readback");
    unmapped_read_a: assert property (rd && addr == 8'h00 |=> rdata == 8'h00) else $error("unmapped read");
    low_ground_a: assert property ($stable(obs_q) && (sel == 6'h00 || (!sel[5] && sel[4:0] > 5'h06))
        |-> !obs_pin) else $error("ground code");
    high_ground_a: assert property ($stable(obs_q) && sel == 6'h20 |-> !obs_pin) else $error("high ground");
    pfd_view_a: assert property ($stable(obs_q) && sel == 6'h05 |-> obs_pin == $past(pfd_up)) else $error("up");
    freq_first_a: assert property ($stable(obs_q) && sel == 6'h27 |-> obs_pin == $past(first_freq_ok))
        else $error("freq1");
    freq_and_a: assert property ($stable(obs_q) && sel == 6'h29 |-> obs_pin == $past(first_freq_ok && second_freq_ok))
        else $error("freq and");
    osc_view_a: assert property ($stable(obs_q) && sel == 6'h2B |-> obs_pin == $past(osc_freq_ok)) else $error("osc");
    ref_sel_a: assert property ($stable(obs_q) && sel == 6'h2C |-> obs_pin == $past(second_ref_sel)) else $error("sel");
    lock_view_a: assert property ($stable(obs_q) && sel == 6'h2D |-> obs_pin == $past(lock_ind)) else $error("lock");
    hold_view_a: assert property ($stable(obs_q) && sel == 6'h2E |-> obs_pin == $past(holdover)) else $error("hold");
endmodule

bind pds_top pds_assertions chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pfd_up(pfd_up), .second_ref_sel(second_ref_sel), .first_freq_ok(first_freq_ok),
    .second_freq_ok(second_freq_ok), .osc_freq_ok(osc_freq_ok), .lock_ind(lock_ind), .holdover(holdover),
    .obs_pin(obs_pin));

// ==== verif/tb.sv ====
// Self-checking bench for pds_top: registers, observation pin and divider periods.
// Assumes the register port answers reads one cycle later with no wait.
`timescale 1ns/1ps
module tb;
    import pds_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, d;
    logic       pfd_up = 0, pfd_down = 0, r1c = 0, r2c = 0, rsel = 0, dm = 0, r1ok = 0, r2ok = 0;
    logic       f1 = 0, f2 = 0, fo = 0, lk = 0, ho = 0;
    logic [7:0] rdata;
    logic       obs_pin, fb_div_out, ref_div_out;
    logic       fb_q = 0, rf_q = 0, pin_q = 0;
    int         err_total = 0, n_tests = 0, cyc = 0, seed, c, a, p, b, n;
    logic [31:0] r;
    int         base [8] = '{1, 2, 2, 4, 8, 16, 32, 3};
    int         bp [3] = '{1, 7, 4};

    always #4 clk = ~clk;

    pds_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pfd_up(pfd_up), .pfd_down(pfd_down), .first_ref_clk(r1c), .second_ref_clk(r2c),
        .second_ref_sel(rsel), .diff_mode(dm), .first_ref_ok(r1ok), .second_ref_ok(r2ok),
        .first_freq_ok(f1), .second_freq_ok(f2), .osc_freq_ok(fo), .lock_ind(lk), .holdover(ho),
        .obs_pin(obs_pin), .fb_div_out(fb_div_out), .ref_div_out(ref_div_out));

    task automatic report_and_stop();
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        // Previous cycle's outputs, for the delayed low observation codes
        fb_q <= fb_div_out;
        rf_q <= ref_div_out;
        pin_q <= obs_pin;
        if (cyc == 40000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic wr_reg(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        wr <= 1'b1; addr <= ad; wdata <= dt;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] ad, output logic [7:0] dt);
        @(posedge clk);
        rd <= 1'b1; addr <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1 dt = rdata;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: rdata %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: obs_pin %b want %b code %0d", $time, got, exp, c);
        end
    endtask

    task automatic cmp_int(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            err_total++;
            $display("unexpected at %0t: period %0d want %0d", $time, got, exp);
        end
    endtask

    // Half period between the second and third toggle; -1 if held
    task automatic measure(input bit use_ref, output int np);
        int   t, seen, t1;
        logic pv;
        #1;
        pv = use_ref ? ref_div_out : fb_div_out;
        seen = 0; t1 = 0; np = -1;
        for (t = 0; t < 1000 && seen < 3; t++) begin
            @(posedge clk);
            #1;
            if ((use_ref ? ref_div_out : fb_div_out) !== pv) begin
                pv = ~pv;
                seen++;
                if (seen == 2) t1 = t;
                if (seen == 3) np = t - t1;
            end
        end
    endtask

    function automatic logic exp_obs(input int cd);
        logic ss;
        ss = (dm || !rsel) ? r1ok : r2ok;
        case (cd)
            1: return fb_q;
            2: return rf_q;
            3: return 1'b0;
            4: return !pin_q;
            5: return pfd_up;
            6: return pfd_down;
            33: return r1c;
            34: return dm ? 1'b0 : r2c;
            35: return (dm || !rsel) ? r1c : r2c;
            36: return dm ? 1'b0 : (rsel ? r1c : r2c);
            37: return ss;
            38: return dm ? 1'b0 : (rsel ? r1ok : r2ok);
            39: return f1;
            40: return f2;
            41: return f1 & f2;
            42: return lk & ss & fo;
            43: return fo;
            44: return rsel;
            45: return lk;
            46: return ho;
            default: return 1'b0;
        endcase
    endfunction

    function automatic int exp_n(input int pc, input int ac, input int bc, input int byp);
        if (pc >= 2 && pc <= 6) return base[pc] * bc + ac;
        if (byp != 0) return base[pc];
        return base[pc] * bc;
    endfunction

    initial begin
        seed = 32'hD22ECB91;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_reg(FEEDBACK_CTL_OFF, d); cmp_byte(d, FEEDBACK_CTL_RST);
        rd_reg(OBS_SEL_OFF, d); cmp_byte(d, OBS_SEL_RST);
        wr_reg(8'h00, 8'hA5);
        rd_reg(8'h00, d); cmp_byte(d, 8'h00);
        for (c = 0; c < 64; c++) begin
            wr_reg(OBS_SEL_OFF, 8'(c << 2));
            repeat (4) begin
                @(posedge clk);
                r = $random(seed);
                {pfd_up, pfd_down, r1c, r2c, rsel, dm, r1ok, r2ok, f1, f2, fo, lk, ho} <= r[12:0];
                @(posedge clk);
                #1 cmp_bit(obs_pin, exp_obs(c));
            end
        end
        rd_reg(OBS_SEL_OFF, d); cmp_byte(d, 8'hFC);
        wr_reg(MAIN_HI_OFF, 8'h00);
        wr_reg(REF_DIV_HI_OFF, 8'h00);
        for (a = 0; a < 2; a++) begin
            for (p = 0; p < 8; p++) begin
                r = $random(seed);
                b = 2 + int'(r[1:0]);
                wr_reg(SWALLOW_OFF, 8'(a));
                wr_reg(MAIN_LO_OFF, 8'(b));
                wr_reg(FEEDBACK_CTL_OFF, 8'(p));
                measure(0, n); cmp_int(n, exp_n(p, a, b, 0));
            end
        end
        for (c = 0; c < 3; c++) begin
            wr_reg(FEEDBACK_CTL_OFF, 8'(8 + bp[c]));
            measure(0, n); cmp_int(n, exp_n(bp[c], 1, b, 1));
        end
        wr_reg(REF_DIV_LO_OFF, 8'h05);
        measure(1, n); cmp_int(n, 5);
        wr_reg(FEEDBACK_CTL_OFF, 8'h21);
        measure(0, n); cmp_int(n, -1);
        measure(1, n); cmp_int(n, 5);
        wr_reg(FEEDBACK_CTL_OFF, 8'h11);
        measure(1, n); cmp_int(n, -1);
        wr_reg(FEEDBACK_CTL_OFF, 8'h41);
        measure(1, n); cmp_int(n, -1);
        measure(0, n); cmp_int(n, exp_n(1, 1, b, 0));
        wr_reg(FEEDBACK_CTL_OFF, 8'h01);
        measure(1, n); cmp_int(n, 5);
        rd_reg(FEEDBACK_CTL_OFF, d); cmp_byte(d, 8'h01);
        report_and_stop();
    end
endmodule
